/* File: qpot_top.sv */
// Serial command interpreter of the quad potentiometer: wipers, setting slots, status.
//
// Contract
// - Frame starts with address byte 010100 plus two strap bits, MSB first.
// - Instruction 1001 00 pp returns selected wiper as third byte, bit 7 first.
// - Instruction 1010 00 pp loads the next eight bits into that wiper.
// - Instruction 1011 rr pp returns the addressed setting slot as third byte.
// - Instruction 1100 rr pp stores the next eight bits into the slot, via NV write.
// - Status instruction 0101 0001 returns seven zeros and the busy flag in bit 0.
// - Instruction 0001 rr 00 copies slot rr of every pot into its wiper.
// - Instruction 1000 rr 00 saves every wiper into its slot rr, via NV write.
// - Instruction 1110 rr pp saves the selected wiper into the selected slot.
// - Instruction 1101 rr pp loads the selected slot into its wiper, no NV write.
// - After 0010 00 pp every further bit until chip select rises steps once.
// - Non-volatile programming starts only after chip select has risen.
// - A step bit of one moves toward the high end, zero toward the low end.
// - Busy flag reads one during a non-volatile write cycle, zero otherwise.
// - A non-volatile write cycle lasts at most 5 ms.
// - After power-up each wiper is loaded from its slot zero.
`timescale 1ns/1ps
`default_nettype none
module qpot_top
	import qpot_pkg::*;
#(
	parameter int         NV_CYCLES = NV_WRITE_CYCLES,
	parameter logic [7:0] SLOT_INIT = SLOT_RESET
) (
	// Clock and reset
	input  wire logic        mclk_i,
	input  wire logic        rst_n_i,
	// Serial pins
	input  wire logic        cs_n_i,
	input  wire logic        sck_i,
	input  wire logic        si_i,
	output logic             so_o,
	output logic             so_oe_n_o,
	// Address straps
	input  wire logic [1:0]  addr_strap_i,
	// Potentiometer state
	output logic      [31:0] wiper_pos_o,
	output logic             write_busy_flag_o
);
	// ----------------------------------------------------------------
	// Pin synchronisation and edge detection
	// ----------------------------------------------------------------
	qpot_pins_s pins_raw;
	qpot_pins_s pins_s;
	logic       sck_d_reg;
	logic       cs_d_reg;
	logic       sck_rise;
	logic       sck_fall;
	logic       cs_rise;
	logic       byte_done;

	assign pins_raw = '{cs_n: cs_n_i, sck: sck_i, si: si_i, strap: addr_strap_i};

	qpot_sync #(.W($bits(qpot_pins_s))) u_sync (
		.mclk_i  (mclk_i),
		.rst_n_i (rst_n_i),
		.async_i (pins_raw),
		.sync_o  (pins_s)
	);

	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
		begin
			sck_d_reg <= 1'b0;
			cs_d_reg  <= 1'b1;
		end
		else
		begin
			sck_d_reg <= pins_s.sck;
			cs_d_reg  <= pins_s.cs_n;
		end
	end

	assign sck_rise = !pins_s.cs_n && pins_s.sck && !sck_d_reg;
	assign sck_fall = !pins_s.cs_n && !pins_s.sck && sck_d_reg;
	assign cs_rise  = pins_s.cs_n && !cs_d_reg;

	// ----------------------------------------------------------------
	// Shift in and frame decode
	// ----------------------------------------------------------------
	qpot_state_e state_reg;
	qpot_state_e instr_next;
	logic [4:0]  bit_cnt_reg;
	logic [7:0]  sr_reg;
	logic [7:0]  sr_next;
	logic [7:0]  instr_reg;
	logic [3:0]  op;
	logic [1:0]  rs;
	logic [1:0]  ps;
	logic        addr_ok;
	logic        busy;

	assign sr_next   = {sr_reg[6:0], pins_s.si};
	assign byte_done = sck_rise && (bit_cnt_reg[2:0] == BYTE_LAST_BIT);
	assign op        = sr_next[7:4];
	assign rs        = sr_next[3:2];
	assign ps        = sr_next[1:0];
	assign addr_ok   = (sr_next[7:2] == ADDR_PREFIX) && (sr_next[1:0] == pins_s.strap);

	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i || pins_s.cs_n)
		begin
			bit_cnt_reg <= 5'h00;
			sr_reg      <= 8'h00;
		end
		else if (sck_rise)
		begin
			sr_reg <= sr_next;
			if (bit_cnt_reg != BIT_CNT_MAX)
				bit_cnt_reg <= bit_cnt_reg + 5'h01;
		end
	end

	always_comb
	begin
		instr_next = ST_IGNORE;
		unique case (op)
			OP_RD_WIPER, OP_WR_WIPER: if (rs == 2'h0) instr_next = ST_DATA;
			OP_RD_SLOT, OP_WR_SLOT: instr_next = ST_DATA;
			OP_SLOT_TO_WIPER, OP_WIPER_TO_SLOT: instr_next = ST_DONE;
			OP_GLB_TO_WIPER, OP_GLB_TO_SLOT: if (ps == 2'h0) instr_next = ST_DONE;
			OP_STEP: if (rs == 2'h0) instr_next = ST_STEP;
			OP_STATUS: if (sr_next == INSTR_STATUS) instr_next = ST_DATA;
			default: instr_next = ST_IGNORE;
		endcase
	end

	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i || pins_s.cs_n)
			state_reg <= ST_ADDR;
		else if (byte_done)
		begin
			unique case (state_reg)
				ST_ADDR: state_reg <= addr_ok ? ST_INSTR : ST_IGNORE;
				ST_INSTR: state_reg <= instr_next;
				ST_DATA: state_reg <= ST_DONE;
				ST_STEP, ST_IGNORE, ST_DONE: state_reg <= state_reg;
			endcase
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
			instr_reg <= 8'h00;
		else if (byte_done && state_reg == ST_INSTR)
			instr_reg <= sr_next;
	end

	// ----------------------------------------------------------------
	// Serial output
	// ----------------------------------------------------------------
	logic [7:0] out_reg;
	logic       is_read;

	assign is_read = (instr_reg[7:4] == OP_RD_WIPER) || (instr_reg[7:4] == OP_RD_SLOT)
		|| (instr_reg == INSTR_STATUS);

	logic [7:0] wiper_reg [0:3];
	logic [7:0] slot_mem  [0:3][0:3];

	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
			out_reg <= 8'h00;
		else if (byte_done && state_reg == ST_INSTR)
		begin
			if (op == OP_RD_WIPER)
				out_reg <= wiper_reg[ps];
			else if (op == OP_RD_SLOT)
				out_reg <= slot_mem[ps][rs];
			else
				out_reg <= {7'h00, busy};
		end
		else if (sck_fall && state_reg == ST_DATA && bit_cnt_reg > DATA_FIRST_BIT)
			out_reg <= {out_reg[6:0], 1'b0};
	end

	// The output stays released in every state but a read data byte.
	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
		begin
			so_o      <= 1'b0;
			so_oe_n_o <= 1'b1;
		end
		else
		begin
			so_o      <= out_reg[7];
			so_oe_n_o <= !(state_reg == ST_DATA && is_read && !pins_s.cs_n);
		end
	end

	// ----------------------------------------------------------------
	// Wiper registers
	// ----------------------------------------------------------------
	logic boot_reg;
	logic step_ev;

	assign step_ev = sck_rise && state_reg == ST_STEP;

	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
			boot_reg <= 1'b1;
		else
			boot_reg <= 1'b0;
	end

	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
		begin
			for (int p = 0; p < 4; p++)
				wiper_reg[p] <= WIPER_MIN;
		end
		else if (boot_reg)
		begin
			for (int p = 0; p < 4; p++)
				wiper_reg[p] <= slot_mem[p][0];
		end
		else if (byte_done && state_reg == ST_INSTR && instr_next == ST_DONE)
		begin
			if (op == OP_GLB_TO_WIPER)
			begin
				for (int p = 0; p < 4; p++)
					wiper_reg[p] <= slot_mem[p][rs];
			end
			else if (op == OP_SLOT_TO_WIPER)
				wiper_reg[ps] <= slot_mem[ps][rs];
		end
		else if (byte_done && state_reg == ST_DATA && instr_reg[7:4] == OP_WR_WIPER)
			wiper_reg[instr_reg[1:0]] <= sr_next;
		else if (step_ev)
		begin
			if (pins_s.si && wiper_reg[instr_reg[1:0]] != WIPER_MAX)
				wiper_reg[instr_reg[1:0]] <= wiper_reg[instr_reg[1:0]] + 8'h01;
			else if (!pins_s.si && wiper_reg[instr_reg[1:0]] != WIPER_MIN)
				wiper_reg[instr_reg[1:0]] <= wiper_reg[instr_reg[1:0]] - 8'h01;
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
			wiper_pos_o <= 32'h00000000;
		else
			wiper_pos_o <= {wiper_reg[3], wiper_reg[2], wiper_reg[1], wiper_reg[0]};
	end

	// ----------------------------------------------------------------
	// Setting slots and non-volatile writes
	// ----------------------------------------------------------------
	logic       pend_reg;
	logic       pend_all_reg;
	logic       pend_wiper_reg;
	logic [7:0] pend_data_reg;
	logic       commit;

	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i || cs_rise)
		begin
			pend_reg       <= 1'b0;
			pend_all_reg   <= 1'b0;
			pend_wiper_reg <= 1'b0;
			pend_data_reg  <= 8'h00;
		end
		else if (byte_done && state_reg == ST_INSTR && instr_next == ST_DONE
			&& (op == OP_GLB_TO_SLOT || op == OP_WIPER_TO_SLOT))
		begin
			pend_reg       <= 1'b1;
			pend_all_reg   <= (op == OP_GLB_TO_SLOT);
			pend_wiper_reg <= 1'b1;
		end
		else if (byte_done && state_reg == ST_DATA && instr_reg[7:4] == OP_WR_SLOT)
		begin
			pend_reg      <= 1'b1;
			pend_data_reg <= sr_next;
		end
	end

	// Writes that end while a cycle is still running are dropped.
	assign commit = cs_rise && pend_reg && !busy;

	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
		begin
			for (int p = 0; p < 4; p++)
				for (int r = 0; r < 4; r++)
					slot_mem[p][r] <= SLOT_INIT;
		end
		else if (commit)
		begin
			if (pend_all_reg)
			begin
				for (int p = 0; p < 4; p++)
					slot_mem[p][instr_reg[3:2]] <= wiper_reg[p];
			end
			else if (pend_wiper_reg)
				slot_mem[instr_reg[1:0]][instr_reg[3:2]] <= wiper_reg[instr_reg[1:0]];
			else
				slot_mem[instr_reg[1:0]][instr_reg[3:2]] <= pend_data_reg;
		end
	end

	qpot_nv_timer #(.CYCLES(NV_CYCLES)) u_nv_timer (
		.mclk_i  (mclk_i),
		.rst_n_i (rst_n_i),
		.start_i (commit),
		.busy_o  (busy)
	);

	assign write_busy_flag_o = busy;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);

	addr_reject_a: assert property (byte_done && state_reg == ST_ADDR && !addr_ok
		|=> state_reg == ST_IGNORE) else $error("bad address not rejected");
	ignore_quiet_a: assert property (state_reg == ST_IGNORE |=> so_oe_n_o)
		else $error("output driven in ignored frame");
	rd_wiper_a: assert property (byte_done && state_reg == ST_INSTR && op == OP_RD_WIPER
		|=> out_reg == wiper_reg[$past(ps)]) else $error("wiper read value wrong");
	wr_wiper_a: assert property (byte_done && state_reg == ST_DATA
		&& instr_reg[7:4] == OP_WR_WIPER |=> wiper_reg[instr_reg[1:0]] == $past(sr_next))
		else $error("wiper write lost");
	status_byte_a: assert property (byte_done && state_reg == ST_INSTR
		&& sr_next == INSTR_STATUS |=> out_reg == {7'h00, $past(busy)})
		else $error("status byte wrong");
	nv_after_cs_a: assert property ($rose(busy) |-> $past(cs_rise))
		else $error("write cycle started inside frame");
	busy_hold_a: assert property ($rose(busy) |-> busy [*4])
		else $error("busy flag dropped early");
	step_sat_a: assert property (step_ev && pins_s.si
		&& wiper_reg[instr_reg[1:0]] == WIPER_MAX |=> wiper_reg[instr_reg[1:0]] == WIPER_MAX)
		else $error("step up wrapped");
	step_down_a: assert property (step_ev && !pins_s.si
		&& wiper_reg[instr_reg[1:0]] != WIPER_MIN
		|=> wiper_reg[instr_reg[1:0]] == $past(wiper_reg[instr_reg[1:0]]) - 8'h01)
		else $error("step down wrong");
	glb_copy_a: assert property (byte_done && state_reg == ST_INSTR && op == OP_GLB_TO_WIPER
		&& ps == 2'h0 |=> wiper_reg[3] == slot_mem[3][$past(rs)])
		else $error("global copy missed");
	boot_load_a: assert property (boot_reg |=> wiper_reg[2] == slot_mem[2][0])
		else $error("boot recall missed");

	read_frame_c: cover property (state_reg == ST_DATA && is_read && sck_fall);
	step_frame_c: cover property (step_ev ##[1:200] step_ev);
	nv_write_c: cover property (commit ##1 busy);
	refused_c: cover property (cs_rise && pend_reg && busy);
endmodule : qpot_top
`default_nettype wire

/* File: qpot_pkg.sv */
// Shared constants, types and timing for the quad potentiometer command interpreter.
`default_nettype none
package qpot_pkg;

	// ----------------------------------------------------------------
	// Frame layout
	// ----------------------------------------------------------------
	localparam logic [5:0] ADDR_PREFIX   = 6'h14;
	localparam logic [2:0] BYTE_LAST_BIT = 3'h7;
	localparam logic [4:0] DATA_FIRST_BIT = 5'h10;
	localparam logic [4:0] BIT_CNT_MAX   = 5'h1F;
	localparam logic [7:0] WIPER_MAX     = 8'hFF;
	localparam logic [7:0] WIPER_MIN     = 8'h00;
	localparam logic [7:0] SLOT_RESET    = 8'h80;

	// ----------------------------------------------------------------
	// Instruction codes (upper nibble of the instruction byte, whole byte for status)
	// ----------------------------------------------------------------
	localparam logic [3:0] OP_RD_WIPER      = 4'h9;
	localparam logic [3:0] OP_WR_WIPER      = 4'hA;
	localparam logic [3:0] OP_RD_SLOT       = 4'hB;
	localparam logic [3:0] OP_WR_SLOT       = 4'hC;
	localparam logic [3:0] OP_SLOT_TO_WIPER = 4'hD;
	localparam logic [3:0] OP_WIPER_TO_SLOT = 4'hE;
	localparam logic [3:0] OP_GLB_TO_WIPER  = 4'h1;
	localparam logic [3:0] OP_GLB_TO_SLOT   = 4'h8;
	localparam logic [3:0] OP_STEP          = 4'h2;
	localparam logic [3:0] OP_STATUS        = 4'h5;
	localparam logic [7:0] INSTR_STATUS     = 8'h51;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ          = 20000000;
	localparam int NV_WRITE_MS     = 5;
	localparam int NV_WRITE_CYCLES = NV_WRITE_MS * (CLK_HZ / 1000);

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_ADDR,
		ST_INSTR,
		ST_DATA,
		ST_STEP,
		ST_IGNORE,
		ST_DONE
	} qpot_state_e;

	typedef struct packed {
		logic       cs_n;
		logic       sck;
		logic       si;
		logic [1:0] strap;
	} qpot_pins_s;

endpackage : qpot_pkg
`default_nettype wire

/* File: qpot_sync.sv */
// Two-flop synchroniser for a vector of asynchronous levels.
`timescale 1ns/1ps
`default_nettype none
module qpot_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         mclk_i,
	input  wire logic         rst_n_i,
	// Levels
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);
	logic [W-1:0] meta_reg;

	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
		begin
			meta_reg <= '1;
			sync_o   <= '1;
		end
		else
		begin
			meta_reg <= async_i;
			sync_o   <= meta_reg;
		end
	end
endmodule : qpot_sync
`default_nettype wire

/* File: qpot_nv_timer.sv */
// Non-volatile write cycle timer that holds the busy flag.
`timescale 1ns/1ps
`default_nettype none
module qpot_nv_timer #(
	parameter int CYCLES = 100000
) (
	// Clock and reset
	input  wire logic mclk_i,
	input  wire logic rst_n_i,
	// Control
	input  wire logic start_i,
	output logic      busy_o
);
	localparam int CW = $clog2(CYCLES + 1);
	logic [CW-1:0] cnt_reg;

	// A start while busy is ignored; the caller refuses such writes.
	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
		begin
			cnt_reg <= '0;
			busy_o  <= 1'b0;
		end
		else if (start_i && !busy_o)
		begin
			cnt_reg <= CW'(CYCLES - 1);
			busy_o  <= 1'b1;
		end
		else if (busy_o)
		begin
			if (cnt_reg == '0)
				busy_o <= 1'b0;
			else
				cnt_reg <= cnt_reg - 1'b1;
		end
	end
endmodule : qpot_nv_timer
`default_nettype wire

/* File: qpot_host.sv */
// Host serial master model that frames commands for the potentiometer interpreter.
`timescale 1ns/1ps
`default_nettype none
module qpot_host (
	// Clock
	input  wire logic mclk_i,
	// Serial pins
	output logic      cs_n_o,
	output logic      sck_o,
	output logic      si_o,
	input  wire logic so_i,
	input  wire logic so_oe_n_i
);
	initial
	begin
		cs_n_o = 1'b1;
		sck_o  = 1'b0;
		si_o   = 1'b0;
	end

	// Half a serial clock period, four system clock cycles.
	task automatic half;
		repeat (4) @(posedge mclk_i);
		#1;
	endtask : half

	// Sends n bits MSB first; collects the data byte and notes any output enable.
	task automatic frame(input logic [31:0] bits, input int n, output logic [7:0] rd,
			output logic drv);
		rd  = 8'h00;
		drv = 1'b0;
		@(posedge mclk_i);
		#1;
		cs_n_o = 1'b0;
		half();
		for (int i = 0; i < n; i++)
		begin
			si_o  = bits[31-i];
			half();
			sck_o = 1'b1;
			repeat (3) @(posedge mclk_i);
			if (i >= 16)
				rd = {rd[6:0], so_oe_n_i ? 1'b1 : so_i};
			if (so_oe_n_i == 1'b0)
				drv = 1'b1;
			@(posedge mclk_i);
			#1;
			sck_o = 1'b0;
		end
		half();
		si_o   = ~si_o;
		cs_n_o = 1'b1;
		half();
		half();
	endtask : frame
endmodule : qpot_host
`default_nettype wire

/* File: testbench.sv */
// Self-checking bench for the quad potentiometer command interpreter.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import qpot_pkg::*;
	localparam int         NVC   = 300;
	localparam logic [7:0] SINIT = 8'h3C;
	logic        mclk, rst_n, cs_n, sck, si, so, so_oe_n, busy, busy_d, early, drv;
	logic [1:0]  strap;
	logic [31:0] wpos;
	logic [7:0]  rd, v;
	logic [15:0] d;
	logic [7:0]  wexp [4];
	logic [7:0]  sexp [4][4];
	int          error_cnt, total_checks, seed, busy_run, busy_len;

	qpot_top #(.NV_CYCLES(NVC), .SLOT_INIT(SINIT)) uut (.mclk_i(mclk), .rst_n_i(rst_n),
		.cs_n_i(cs_n), .sck_i(sck), .si_i(si), .so_o(so), .so_oe_n_o(so_oe_n),
		.addr_strap_i(strap), .wiper_pos_o(wpos), .write_busy_flag_o(busy));
	qpot_host host (.mclk_i(mclk), .cs_n_o(cs_n), .sck_o(sck), .si_o(si), .so_i(so),
		.so_oe_n_i(so_oe_n));

	// ----------------------------------------------------------------
	// Clock, busy monitors and checking helpers
	// ----------------------------------------------------------------
	initial mclk = 1'b0;
	always #25 mclk = ~mclk;

	always @(posedge mclk)
	begin
		busy_d <= busy;
		if (cs_n === 1'b0 && busy === 1'b1 && busy_d === 1'b0)
			early <= 1'b1;
		if (busy === 1'b1)
			busy_run <= busy_run + 1;
		else if (busy_run != 0)
		begin
			busy_len <= busy_run;
			busy_run <= 0;
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		total_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask : chk

	task automatic chk_bit(input logic got, input logic exp, input string msg);
		total_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[FAIL] %0t %s got %b exp %b", $time, msg, got, exp);
		end
	endtask : chk_bit

	task automatic final_report;
		if (error_cnt == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : final_report

	function automatic logic [15:0] hdr(input logic [3:0] op, input logic [1:0] r,
			input logic [1:0] p);
		return {ADDR_PREFIX, strap, op, r, p};
	endfunction : hdr

	function automatic logic [7:0] stepm(input logic [7:0] w, input logic [15:0] s,
			input int n);
		for (int i = 0; i < n; i++)
			if (s[15-i])
				w = (w == WIPER_MAX) ? w : w + 8'h01;
			else
				w = (w == WIPER_MIN) ? w : w - 8'h01;
		return w;
	endfunction : stepm

	task automatic xfer(input logic [31:0] b, input int n);
		host.frame(b, n, rd, drv);
	endtask : xfer

	task automatic rd_reg(input logic [3:0] op, input logic [1:0] r, input logic [1:0] p);
		xfer({hdr(op, r, p), 16'h0000}, 24);
	endtask : rd_reg

	task automatic wr_wiper(input logic [1:0] p, input logic [7:0] val);
		xfer({hdr(OP_WR_WIPER, 2'h0, p), val, 8'h00}, 24);
		wexp[p] = val;
	endtask : wr_wiper

	task automatic chk_wipers;
		chk(wpos, {wexp[3], wexp[2], wexp[1], wexp[0]}, "wiper positions");
	endtask : chk_wipers

	task automatic nv_wait;
		rd_reg(OP_STATUS, 2'h0, 2'h1);
		chk(rd, 8'h01, "status while writing");
		for (int i = 0; i < 2000 && busy !== 1'b0; i++)
			@(posedge mclk);
		@(posedge mclk);
		#1;
		chk(busy_len, NVC, "busy length");
		rd_reg(OP_STATUS, 2'h0, 2'h1);
		chk(rd, 8'h00, "status when idle");
	endtask : nv_wait

	// ----------------------------------------------------------------
	// Watchdog and main sequence
	// ----------------------------------------------------------------
	initial
	begin
		#2000000;
		error_cnt++;
		final_report();
	end

	initial
	begin
		seed = 76181;
		error_cnt = 0;
		total_checks = 0;
		busy_run = 0;
		busy_len = 0;
		early = 1'b0;
		busy_d = 1'b0;
		rst_n = 1'b0;
		strap = 2'($random(seed));
		repeat (20) @(posedge mclk);
		#1;
		rst_n = 1'b1;
		repeat (4) @(posedge mclk);
		#1;
		for (int i = 0; i < 4; i++)
		begin
			wexp[i] = SINIT;
			for (int j = 0; j < 4; j++)
				sexp[i][j] = SINIT;
		end
		chk_wipers();
		for (int p = 0; p < 4; p++)
		begin
			wr_wiper(2'(p), 8'($random(seed)));
			chk_wipers();
			rd_reg(OP_RD_WIPER, 2'h0, 2'(p));
			chk(rd, wexp[p], "wiper read");
			chk_bit(drv, 1'b1, "read drives output");
		end
		rd_reg(OP_RD_WIPER, 2'h1, 2'h0);
		chk_bit(drv, 1'b0, "bad fixed bits drive");
		for (int r = 0; r < 4; r++)
		begin
			v = 8'($random(seed));
			xfer({hdr(OP_WR_SLOT, 2'(r), 2'(3 - r)), v, 8'h00}, 24);
			sexp[3-r][r] = v;
			nv_wait();
			rd_reg(OP_RD_SLOT, 2'(r), 2'(3 - r));
			chk(rd, v, "slot read");
		end
		xfer({hdr(OP_WIPER_TO_SLOT, 2'h1, 2'h2), 16'h0000}, 16);
		sexp[2][1] = wexp[2];
		nv_wait();
		rd_reg(OP_RD_SLOT, 2'h1, 2'h2);
		chk(rd, wexp[2], "single save");
		xfer({hdr(OP_GLB_TO_SLOT, 2'h3, 2'h0), 16'h0000}, 16);
		nv_wait();
		for (int p = 0; p < 4; p++)
		begin
			sexp[p][3] = wexp[p];
			rd_reg(OP_RD_SLOT, 2'h3, 2'(p));
			chk(rd, wexp[p], "global save");
		end
		xfer({hdr(OP_GLB_TO_WIPER, 2'h0, 2'h0), 16'h0000}, 16);
		for (int p = 0; p < 4; p++)
			wexp[p] = sexp[p][0];
		chk_wipers();
		xfer({hdr(OP_SLOT_TO_WIPER, 2'h2, 2'h1), 16'h0000}, 16);
		wexp[1] = sexp[1][2];
		chk_wipers();
		chk_bit(busy, 1'b0, "no write on recall");
		wr_wiper(2'h2, 8'hFE);
		xfer({hdr(OP_STEP, 2'h0, 2'h2), 16'hE000}, 19);
		wexp[2] = WIPER_MAX;
		chk_wipers();
		wr_wiper(2'h0, 8'h01);
		xfer({hdr(OP_STEP, 2'h0, 2'h0), 16'h0000}, 19);
		wexp[0] = WIPER_MIN;
		chk_wipers();
		d = 16'($random(seed));
		xfer({hdr(OP_STEP, 2'h0, 2'h3), d}, 28);
		wexp[3] = stepm(wexp[3], d, 12);
		chk_wipers();
		xfer({ADDR_PREFIX, ~strap, OP_RD_WIPER, 4'h0, 16'h0000}, 24);
		chk_bit(drv, 1'b0, "foreign address drives");
		xfer({ADDR_PREFIX, ~strap, OP_WR_WIPER, 4'h1, 8'h5A, 8'h00}, 24);
		chk_wipers();
		chk_bit(early, 1'b0, "write started inside frame");
		final_report();
	end
endmodule : testbench
`default_nettype wire
